//--- include/hc_cmd_pkg.sv
// package: access codes, field layout, reset values and timing of the
// host command and status register bank.
// assumes a single 200 MHz clock and a synchronous active-high reset.
`default_nettype none
package hc_cmd_pkg;
   // access codes: read code, write code is read code plus 80h
   localparam logic [7:0] CODE_CTRL_RD = 8'h01;
   localparam logic [7:0] CODE_CTRL_WR = 8'h81;
   localparam logic [7:0] CODE_CS_RD = 8'h02;
   localparam logic [7:0] CODE_CS_WR = 8'h82;
   localparam logic [7:0] CODE_IS_RD = 8'h03;
   localparam logic [7:0] CODE_IS_WR = 8'h83;
   // field positions
   localparam int CS_HCR_BIT = 0;
   localparam int CS_SOC_LSB = 16;
   localparam int SOC_W = 2;
   localparam int IS_SO_BIT = 0;
   localparam int CTRL_FS_LSB = 6;
   localparam int FS_W = 2;
   // reset values
   localparam logic [1:0] SOC_RESET = 2'h0;
   localparam logic SO_RESET = 1'b0;
   localparam logic HCR_RESET = 1'b0;
   // functional state encoding
   typedef enum logic [1:0] {
      FS_USB_RESET = 2'h0,
      FS_RESUME = 2'h1,
      FS_OPERATIONAL = 2'h2,
      FS_SUSPENDED = 2'h3
   } fs_e;
   // timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int SW_RESET_MAX_MS = 10;
   localparam int SW_RESET_MAX_CYC =
      SW_RESET_MAX_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SW_RESET_HOLD_CYC = 16;
   localparam int HOLD_W = 5;
endpackage
`default_nettype wire

//--- include/hc_core_if.sv
// interface: links the register front end to the overrun counter and
// the soft reset sequencer.
// assumes all three sit on the same clock.
`default_nettype none
interface hc_core_if;
   logic reset_start;
   logic reset_busy;
   logic reset_done;
   logic ops_reset;
   logic so_clear;
   logic overrun;
   logic [1:0] soc;
   logic so_flag;
   modport front (output reset_start, output so_clear,
                  input reset_busy, input reset_done, input ops_reset,
                  input overrun, input soc, input so_flag);
   modport seq (input reset_start, output reset_busy,
                output reset_done, output ops_reset);
   modport ovr (input so_clear, input ops_reset, input reset_busy,
                output overrun, output soc, output so_flag);
endinterface
`default_nettype wire

//--- logic/host_command_status_reg.sv
// host command and status register bank with control functional state
// and the schedule overrun flag of the interrupt status register.
// assumes access requests arrive as one-cycle strobes with a code byte.
`default_nettype none
// How it works
// [R1] a write to the command status register sets each writable bit written as one and leaves bits written as zero alone.
// [R2] a read returns all implemented bits as they stand and changes none of them.
// [R3] code 02h reads and code 82h writes the command status register.
// [R4] an overrun is seen when the periodic list is unfinished at end of frame and no soft reset is busy.
// [R5] each overrun steps the count in bits 17 to 16 and sets the overrun flag.
// [R6] the count starts at 00, wraps from 11 to 00 and cannot be written.
// [R7] the count still steps while the overrun flag is already set.
// [R8] writing one to bit 0 starts a soft reset of the controller.
// [R9] a soft reset forces the suspended state and resets the operational registers.
// [R10] bit 0 clears itself when the soft reset ends, well inside 10 ms.
// [R11] a soft reset neither resets the root hub nor drives port reset.
// [R12] the functional state encodes reset 00, resume 01, operational 10, suspended 11.
// [R13] writing one to the overrun flag clears it; writing cannot set it.
// [R14] reserved bits read as zero and ignore writes.
module host_command_status_reg
#(
   parameter int reset_max_cycles = hc_cmd_pkg::SW_RESET_MAX_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register access
   input wire logic acc_valid,
   input wire logic [7:0] acc_code,
   input wire logic [31:0] acc_wdata,
   output logic [31:0] rd_data,
   output logic rd_valid,
   // frame timing
   input wire logic frame_end,
   input wire logic periodic_done,
   // controller state
   output logic [1:0] functional_state,
   output logic ops_reset,
   output logic soft_reset_busy,
   output logic sched_overrun
);
   import hc_cmd_pkg::*;

   hc_core_if core ();

   logic [1:0] fs;
   logic [1:0] next_fs;
   logic [31:0] next_rd_data;
   logic next_rd_valid;
   logic ops_reset_q;
   logic busy_q;
   logic so_q;
   logic wr_cs;
   logic wr_ctrl;
   logic wr_is;
   logic [31:0] cs_word;
   logic [31:0] is_word;
   logic [31:0] ctrl_word;

   // decode of write codes
   assign wr_cs = acc_valid && (acc_code == CODE_CS_WR); // [R3]
   assign wr_ctrl = acc_valid && (acc_code == CODE_CTRL_WR);
   assign wr_is = acc_valid && (acc_code == CODE_IS_WR);

   // write-to-set: only bit 0 is implemented, zero writes do nothing
   // a fresh write in the done cycle wins over the self clear
   assign core.reset_start = wr_cs && acc_wdata[CS_HCR_BIT]
      && (!core.reset_busy || core.reset_done); // [R1] [R8]
   // only a one clears the flag
   assign core.so_clear = wr_is && acc_wdata[IS_SO_BIT]; // [R13]

   // read images, reserved bits held at zero
   always_comb
   begin
      cs_word = '0; // [R14]
      cs_word[CS_SOC_LSB +: SOC_W] = core.soc; // [R2]
      cs_word[CS_HCR_BIT] = core.reset_busy; // [R2]
      is_word = '0;
      is_word[IS_SO_BIT] = core.so_flag;
      ctrl_word = '0;
      ctrl_word[CTRL_FS_LSB +: FS_W] = fs;
   end

   // read path
   always_comb
   begin
      next_rd_valid = acc_valid && !acc_code[7];
      next_rd_data = '0;
      if (acc_valid)
      begin
         case (acc_code)
            CODE_CS_RD: next_rd_data = cs_word; // [R3]
            CODE_IS_RD: next_rd_data = is_word;
            CODE_CTRL_RD: next_rd_data = ctrl_word;
            default: next_rd_data = '0;
         endcase
      end
   end

   // functional state
   always_comb
   begin
      next_fs = fs;
      if (core.reset_start || core.reset_busy)
         next_fs = FS_SUSPENDED; // [R9] [R12]
      else if (wr_ctrl)
         next_fs = acc_wdata[CTRL_FS_LSB +: FS_W]; // [R12]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         fs <= FS_USB_RESET;
         rd_data <= '0;
         rd_valid <= 1'b0;
         ops_reset_q <= 1'b0;
         busy_q <= 1'b0;
         so_q <= 1'b0;
      end
      else
      begin
         fs <= next_fs;
         rd_data <= next_rd_data;
         rd_valid <= next_rd_valid;
         ops_reset_q <= core.ops_reset; // [R9]
         busy_q <= core.reset_busy;
         so_q <= core.so_flag;
      end
   end

   // the soft reset reaches no root hub or port reset output
   assign functional_state = fs; // [R11]
   assign ops_reset = ops_reset_q;
   assign soft_reset_busy = busy_q;
   assign sched_overrun = so_q;

   overrun_counter u_ovr (
      .clk(clk),
      .rst(rst),
      .frame_end(frame_end),
      .periodic_done(periodic_done),
      .core(core.ovr)
   );

   soft_reset_seq u_seq (
      .clk(clk),
      .rst(rst),
      .core(core.seq)
   );

   // cycles spent in one soft reset
   int busy_cnt;
   always_ff @(posedge clk)
   begin
      if (rst || !core.reset_busy || core.reset_start)
         busy_cnt <= 0;
      else
         busy_cnt <= busy_cnt + 1;
   end

   property p_write_sets;
      @(posedge clk) disable iff (rst)
      (wr_cs && acc_wdata[CS_HCR_BIT]) |=> core.reset_busy;
   endproperty
   a_write_sets: assert property (p_write_sets) // [R1]
      else $error("write of one did not set reset bit");

   property p_zero_write_keeps;
      @(posedge clk) disable iff (rst)
      (wr_cs && !acc_wdata[CS_HCR_BIT] && !core.reset_busy)
         |=> !core.reset_busy;
   endproperty
   a_zero_write_keeps: assert property (p_zero_write_keeps) // [R1]
      else $error("write of zero changed reset bit");

   property p_read_image;
      @(posedge clk) disable iff (rst)
      (acc_valid && acc_code == CODE_CS_RD) |=> rd_valid
         && rd_data[CS_SOC_LSB +: SOC_W] == $past(core.soc)
         && rd_data[CS_HCR_BIT] == $past(core.reset_busy);
   endproperty
   a_read_image: assert property (p_read_image) // [R2] [R3]
      else $error("command status read returned wrong value");

   property p_reserved_zero;
      @(posedge clk) disable iff (rst)
      (acc_valid && acc_code == CODE_CS_RD) |=>
         rd_data[31:18] == 14'h0 && rd_data[15:1] == 15'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // [R14]
      else $error("reserved bits read nonzero");

   property p_soc_readonly;
      @(posedge clk) disable iff (rst)
      (wr_cs && !core.overrun && !core.ops_reset && !core.reset_busy
         && !(frame_end && !periodic_done)) |=> $stable(core.soc);
   endproperty
   a_soc_readonly: assert property (p_soc_readonly) // [R6]
      else $error("overrun count changed by a write");

   property p_overrun_flag;
      @(posedge clk) disable iff (rst)
      (frame_end && !periodic_done && !core.reset_busy)
         |=> core.so_flag ##1 sched_overrun;
   endproperty
   a_overrun_flag: assert property (p_overrun_flag) // [R4] [R5]
      else $error("overrun not flagged");

   property p_enter_suspend;
      @(posedge clk) disable iff (rst)
      core.reset_start |=> fs == FS_SUSPENDED
         ##1 (fs == FS_SUSPENDED) [*8];
   endproperty
   a_enter_suspend: assert property (p_enter_suspend) // [R9] [R12]
      else $error("soft reset did not force suspended state");

   property p_reset_bounded;
      @(posedge clk) disable iff (rst)
      busy_cnt <= reset_max_cycles;
   endproperty
   a_reset_bounded: assert property (p_reset_bounded) // [R10]
      else $error("soft reset exceeded its time limit");

   property p_self_clear;
      @(posedge clk) disable iff (rst)
      core.reset_start |-> ##[1:20] core.reset_done;
   endproperty
   a_self_clear: assert property (p_self_clear) // [R10] [R8]
      else $error("reset bit did not clear itself");

   property p_flag_clear;
      @(posedge clk) disable iff (rst)
      (core.so_clear && !core.overrun && !(frame_end && !periodic_done))
         |=> !core.so_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) // [R13]
      else $error("overrun flag not cleared by write of one");

   property p_no_sw_set;
      @(posedge clk) disable iff (rst)
      (!core.so_flag && !(frame_end && !periodic_done)) |=> !core.so_flag;
   endproperty
   a_no_sw_set: assert property (p_no_sw_set) // [R13]
      else $error("overrun flag set without an overrun");

   property p_restart_in_done;
      @(posedge clk) disable iff (rst)
      (wr_cs && acc_wdata[CS_HCR_BIT] && core.reset_done) |=> core.ops_reset;
   endproperty
   a_restart_in_done: assert property (p_restart_in_done) // [R1] [R8]
      else $error("write of one in the done cycle was lost");

   property p_done_clears;
      @(posedge clk) disable iff (rst)
      (core.reset_done && !core.reset_start) |=> !core.reset_busy;
   endproperty
   a_done_clears: assert property (p_done_clears) // [R10]
      else $error("reset bit stayed set after the done cycle");

   property p_done_length;
      @(posedge clk) disable iff (rst)
      core.reset_done |-> busy_cnt == SW_RESET_HOLD_CYC;
   endproperty
   a_done_length: assert property (p_done_length) // [R10]
      else $error("soft reset done after the wrong number of cycles");

   property p_suspend_while_busy;
      @(posedge clk) disable iff (rst)
      core.reset_busy |-> fs == FS_SUSPENDED;
   endproperty
   a_suspend_while_busy: assert property (p_suspend_while_busy) // [R9] [R12]
      else $error("state left suspended during soft reset");

   property p_ctrl_write;
      @(posedge clk) disable iff (rst)
      (wr_ctrl && !core.reset_busy && !core.reset_start)
         |=> fs == $past(acc_wdata[CTRL_FS_LSB +: FS_W]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) // [R12]
      else $error("functional state write not taken");

   property p_ops_clears;
      @(posedge clk) disable iff (rst)
      core.ops_reset |=> core.soc == SOC_RESET && !core.so_flag;
   endproperty
   a_ops_clears: assert property (p_ops_clears) // [R9]
      else $error("operational reset left count or flag set");

   property p_write_no_answer;
      @(posedge clk) disable iff (rst)
      (acc_valid && acc_code[7]) |=> !rd_valid && rd_data == 32'h0000_0000;
   endproperty
   a_write_no_answer: assert property (p_write_no_answer) // [R3]
      else $error("write code produced a read answer");

   property p_overrun_seen;
      @(posedge clk) disable iff (rst)
      core.overrun |=> sched_overrun;
   endproperty
   a_overrun_seen: assert property (p_overrun_seen) // [R5]
      else $error("overrun not shown on the overrun output");
endmodule // host_command_status_reg
`default_nettype wire

//--- logic/overrun_counter.sv
// overrun detection, overrun frame count and the schedule overrun flag.
// assumes frame_end is a one-cycle pulse at each end of frame.
`default_nettype none
module overrun_counter
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // frame timing
   input wire logic frame_end,
   input wire logic periodic_done,
   // core link
   hc_core_if.ovr core
);
   import hc_cmd_pkg::*;

   logic [1:0] soc;
   logic so_flag;
   logic overrun;
   logic [1:0] next_soc;
   logic next_so_flag;
   logic next_overrun;

   always_comb
   begin
      // periodic list unfinished when the frame ends
      next_overrun = frame_end && !periodic_done && !core.reset_busy; // [R4]
      next_soc = soc;
      next_so_flag = so_flag;
      if (core.ops_reset)
      begin
         next_soc = SOC_RESET;
         next_so_flag = SO_RESET;
      end
      else
      begin
         if (core.so_clear)
            next_so_flag = 1'b0; // [R13]
         if (next_overrun)
         begin
            next_soc = soc + 2'h1; // [R5] [R6] [R7]
            next_so_flag = 1'b1; // [R5]
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         soc <= SOC_RESET; // [R6]
         so_flag <= SO_RESET;
         overrun <= 1'b0;
      end
      else
      begin
         soc <= next_soc;
         so_flag <= next_so_flag;
         overrun <= next_overrun;
      end
   end

   assign core.soc = soc;
   assign core.so_flag = so_flag;
   assign core.overrun = overrun;

   property p_soc_wraps;
      @(posedge clk) disable iff (rst)
      (next_overrun && !core.ops_reset) |=> soc == $past(soc) + 2'h1;
   endproperty
   a_soc_wraps: assert property (p_soc_wraps) // [R6]
      else $error("overrun count did not step by one");

   property p_so_set_wins;
      @(posedge clk) disable iff (rst)
      (next_overrun && core.so_clear && !core.ops_reset) |=> so_flag;
   endproperty
   a_so_set_wins: assert property (p_so_set_wins) // [R5] [R13]
      else $error("overrun flag lost against its clear");
endmodule // overrun_counter
`default_nettype wire

//--- logic/soft_reset_seq.sv
// soft reset sequencer: holds the operational reset for a fixed time,
// then reports completion.
// assumes reset_start is a one-cycle pulse taken only while idle or done.
`default_nettype none
module soft_reset_seq
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // core link
   hc_core_if.seq core
);
   import hc_cmd_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_HOLD = 2'h1,
      ST_DONE = 2'h3
   } seq_e;

   seq_e state;
   seq_e next_state;
   logic [HOLD_W-1:0] cnt;
   logic [HOLD_W-1:0] next_cnt;

   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         ST_IDLE:
         begin
            next_cnt = '0;
            if (core.reset_start)
               next_state = ST_HOLD; // [R8]
         end
         ST_HOLD:
         begin
            next_cnt = cnt + HOLD_W'(1);
            if (cnt == HOLD_W'(SW_RESET_HOLD_CYC - 1))
               next_state = ST_DONE; // [R10]
         end
         ST_DONE:
         begin
            next_cnt = '0;
            if (core.reset_start)
               next_state = ST_HOLD; // [R8]
            else
               next_state = ST_IDLE; // [R10]
         end
         default:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= ST_IDLE;
         cnt <= '0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // busy doubles as the soft reset bit; it drops after the done cycle
   assign core.reset_busy = (state != ST_IDLE); // [R10]
   assign core.ops_reset = (state == ST_HOLD); // [R9]
   assign core.reset_done = (state == ST_DONE);

   property p_hold_length;
      @(posedge clk) disable iff (rst)
      $rose(core.ops_reset) |-> core.ops_reset [*8] ##0 1;
   endproperty
   a_hold_length: assert property (p_hold_length) // [R9]
      else $error("operational reset released too early");
endmodule // soft_reset_seq
`default_nettype wire

//--- verif/tb.sv
// testbench for the host command and status register bank.
// assumes the design package and core interface are compiled first.
`default_nettype none

`define check(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) \
      begin \
         num_errors++; \
         $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
      end \
   end

module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import hc_cmd_pkg::*;

   localparam int RST_MAX = 32;
   localparam int CYCLE_LIMIT = 3000;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic acc_valid = 1'b0;
   logic [7:0] acc_code = 8'h00;
   logic [31:0] acc_wdata = 32'h0000_0000;
   logic frame_end = 1'b0;
   logic periodic_done = 1'b1;
   logic [31:0] rd_data;
   logic rd_valid;
   logic [1:0] functional_state;
   logic ops_reset;
   logic soft_reset_busy;
   logic sched_overrun;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [31:0] d;
   int n;

   host_command_status_reg #(.reset_max_cycles(RST_MAX)) dut
   (
      .clk(clk),
      .rst(rst),
      .acc_valid(acc_valid),
      .acc_code(acc_code),
      .acc_wdata(acc_wdata),
      .rd_data(rd_data),
      .rd_valid(rd_valid),
      .frame_end(frame_end),
      .periodic_done(periodic_done),
      .functional_state(functional_state),
      .ops_reset(ops_reset),
      .soft_reset_busy(soft_reset_busy),
      .sched_overrun(sched_overrun)
   );

   always #2.5 clk = ~clk;

   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles >= CYCLE_LIMIT)
      begin
         num_errors++;
         give_verdict();
      end
   end

   // one write strobe, then one idle cycle
   task automatic wr(input logic [7:0] c, input logic [31:0] w);
      @(negedge clk);
      acc_valid = 1'b1;
      acc_code = c;
      acc_wdata = w;
      @(negedge clk);
      acc_valid = 1'b0;
      acc_code = 8'h00;
      acc_wdata = 32'h0000_0000;
   endtask

   // one read strobe; data sampled in the answer cycle
   task automatic rd(input logic [7:0] c, output logic [31:0] q);
      @(negedge clk);
      acc_valid = 1'b1;
      acc_code = c;
      @(negedge clk);
      `check(rd_valid, 1'b1)
      q = rd_data;
      acc_valid = 1'b0;
      acc_code = 8'h00;
   endtask

   task automatic rd_chk(input logic [7:0] c, input logic [31:0] e);
      logic [31:0] q;
      rd(c, q);
      `check(q, e)
   endtask

   // one end of frame, periodic list finished or not
   task automatic frame(input logic done);
      @(negedge clk);
      frame_end = 1'b1;
      periodic_done = done;
      @(negedge clk);
      frame_end = 1'b0;
      periodic_done = 1'b1;
   endtask

   initial
   begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      // reset values
      rd_chk(CODE_CS_RD, 32'h0000_0000);
      rd_chk(CODE_IS_RD, 32'h0000_0000);
      rd_chk(CODE_CTRL_RD, 32'h0000_0000);
      rd_chk(8'h05, 32'h0000_0000);
      // finished periodic list is no overrun
      frame(1'b1);
      rd_chk(CODE_CS_RD, 32'h0000_0000);
      rd_chk(CODE_IS_RD, 32'h0000_0000);
      // count steps on every overrun and wraps
      for (int i = 1; i <= 5; i++)
      begin
         frame(1'b0);
         rd_chk(CODE_CS_RD, {14'h0, 2'(i % 4), 16'h0});
         `check(sched_overrun, 1'b1)
      end
      // count and reserved bits ignore writes
      wr(CODE_CS_WR, 32'hFFFF_FFFE);
      `check(rd_valid, 1'b0)
      rd_chk(CODE_CS_RD, 32'h0001_0000);
      rd_chk(CODE_CS_RD, 32'h0001_0000);
      rd_chk(CODE_IS_RD, 32'h0000_0001);
      // overrun flag clears on one, zero leaves it
      wr(CODE_IS_WR, 32'hFFFF_FFFE);
      rd_chk(CODE_IS_RD, 32'h0000_0001);
      wr(CODE_IS_WR, 32'h0000_0001);
      rd_chk(CODE_IS_RD, 32'h0000_0000);
      wr(CODE_IS_WR, 32'h0000_0001);
      rd_chk(CODE_IS_RD, 32'h0000_0000);
      // every functional state code
      for (int s = 0; s < 4; s++)
      begin
         wr(CODE_CTRL_WR, 32'(s << 6));
         rd_chk(CODE_CTRL_RD, 32'(s << 6));
         `check(functional_state, 2'(s))
      end
      wr(CODE_CTRL_WR, 32'h0000_0080);
      frame(1'b0);
      rd_chk(CODE_CS_RD, 32'h0002_0000);
      // soft reset from operational
      wr(CODE_CS_WR, 32'h0000_0001);
      rd(CODE_CS_RD, d);
      `check(d[0], 1'b1)
      `check(functional_state, 2'h3)
      `check(ops_reset, 1'b1)
      `check(soft_reset_busy, 1'b1)
      wr(CODE_CTRL_WR, 32'h0000_0080);
      wr(CODE_CS_WR, 32'h0000_0000);
      rd_chk(CODE_CTRL_RD, 32'h0000_00C0);
      `check(soft_reset_busy, 1'b1)
      n = 0;
      while (soft_reset_busy !== 1'b0 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      `check(n < RST_MAX, 1'b1)
      rd_chk(CODE_CS_RD, 32'h0000_0000);
      rd_chk(CODE_IS_RD, 32'h0000_0000);
      `check(ops_reset, 1'b0)
      `check(functional_state, 2'h3)
      // counting resumes after the reset
      frame(1'b0);
      rd_chk(CODE_CS_RD, 32'h0001_0000);
      give_verdict();
   end
endmodule // tb

`default_nettype wire
